// *** hw/ilst_table.sv ***
// Purpose: unit, latency and serialization lookup with issue holds
// Assumes: dispatch re-presents a held instruction every cycle
// Notes:   outputs lag the decoded instruction by one clock
`timescale 1ns/1ns
`default_nettype none

module ilst_table (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       dec_valid,
   input  wire ilst_pkg::ilst_op_e         dec_op,
   input  wire logic [7:0]                 dec_crm,
   input  wire logic [ilst_pkg::NREG_W-1:0] dec_nregs,
   input  wire logic                       dec_early_exit,
   input  wire logic                       issue,
   input  wire logic                       fp_complete,
   output ilst_pkg::ilst_unit_e            out_unit,
   output logic [ilst_pkg::LAT_W-1:0]      out_latency,
   output logic                            out_lat_fixed,
   output ilst_pkg::ilst_ser_e             out_ser,
   output logic                            out_valid,
   output logic                            out_hold,
   output logic                            out_flush_on_exec,
   output logic                            flush_req
);

   ilst_pkg::ilst_unit_e       lk_unit;
   logic [ilst_pkg::LAT_W-1:0] lk_lat;
   logic                       lk_fixed;
   ilst_pkg::ilst_ser_e        lk_ser;
   logic                       lk_flush;
   logic                       lk_mul_stall;
   logic                       lk_div;

   logic held_mul_stall;
   logic held_div;
   logic next_held_mul_stall;
   logic next_held_div;

   logic next_out_valid;
   logic next_out_hold;
   logic next_flush_req;

   logic iss;
   logic iss_fp;
   logic iss_fp_empty;
   logic multi_cycle_int_unit_next_busy;
   logic fp_next_idle;
   logic fp_next_empty_active;

   // table lookup on the instruction decoded this cycle
   always_comb begin
      lk_unit      = ilst_pkg::UNIT_NONE;
      lk_lat       = ilst_pkg::LAT_NONE;
      lk_fixed     = 1'b0;
      lk_ser       = ilst_pkg::SER_NONE;
      lk_flush     = 1'b0;
      lk_mul_stall = 1'b0;
      lk_div       = 1'b0;
      case (dec_op)
         ilst_pkg::OP_MUL_WORD: begin
            lk_unit      = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
            lk_lat       = dec_early_exit ? ilst_pkg::LAT_MUL_EARLY : ilst_pkg::LAT_MUL;
            lk_fixed     = 1'b1;
            lk_mul_stall = !dec_early_exit;
         end
         ilst_pkg::OP_MULLI: begin
            lk_unit  = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_THREE;
            lk_fixed = 1'b1;
         end
         ilst_pkg::OP_MTCRF: begin
            lk_lat   = ilst_pkg::LAT_ONE;
            lk_fixed = 1'b1;
            if (ilst_pkg::ilst_popcount8(dec_crm) == ilst_pkg::CR_ONE_FIELD) begin
               lk_unit = ilst_pkg::UNIT_SINGLE_CYCLE_INT_UNIT;
            end else begin
               lk_unit = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
               lk_ser  = ilst_pkg::SER_DISP_EXEC;
            end
         end
         ilst_pkg::OP_MF_SLOW: begin
            lk_unit  = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_THREE;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_EXECUTE;
         end
         ilst_pkg::OP_MT_LRCTR: begin
            lk_unit  = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_ONE;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_DISPATCH;
         end
         ilst_pkg::OP_MT_MSR_SPR: begin
            lk_unit  = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_ONE;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_EXECUTE;
         end
         ilst_pkg::OP_MT_XER: begin
            lk_unit  = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_ONE;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_COMPLETE;
            lk_flush = 1'b1;
         end
         ilst_pkg::OP_STORE: begin
            lk_unit  = ilst_pkg::UNIT_LSU;
            lk_lat   = ilst_pkg::LAT_THREE;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_EXECUTE;
         end
         ilst_pkg::OP_STORE_MULT: begin
            lk_unit  = ilst_pkg::UNIT_LSU;
            // widen before adding so 32 registers cannot wrap
            lk_lat   = {1'b0, dec_nregs} + ilst_pkg::LAT_STR_EXTRA;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_STR_MULT;
         end
         ilst_pkg::OP_SINGLE_CYCLE_INT_UNIT_SIMPLE: begin
            lk_unit  = ilst_pkg::UNIT_SINGLE_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_ONE;
            lk_fixed = 1'b1;
         end
         ilst_pkg::OP_SUBF_EXT: begin
            lk_unit  = ilst_pkg::UNIT_SINGLE_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_ONE;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_EXECUTE;
         end
         ilst_pkg::OP_SC_RFI: begin
            lk_unit = ilst_pkg::UNIT_COMPL;
            lk_ser  = ilst_pkg::SER_POSTDISP;
         end
         ilst_pkg::OP_FPSCR: begin
            lk_unit  = ilst_pkg::UNIT_FPU;
            lk_lat   = ilst_pkg::LAT_THREE;
            lk_fixed = 1'b1;
         end
         ilst_pkg::OP_FP_ARITH: begin
            lk_unit  = ilst_pkg::UNIT_FPU;
            lk_lat   = ilst_pkg::LAT_THREE;
            lk_fixed = 1'b1;
         end
         ilst_pkg::OP_FDIV: begin
            lk_unit  = ilst_pkg::UNIT_FPU;
            lk_lat   = ilst_pkg::LAT_FDIV;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_FP_EMPTY;
         end
         ilst_pkg::OP_FDIVS_FRES: begin
            lk_unit  = ilst_pkg::UNIT_FPU;
            lk_lat   = ilst_pkg::LAT_FDIVS;
            lk_fixed = 1'b1;
            lk_ser   = ilst_pkg::SER_FP_EMPTY;
         end
         ilst_pkg::OP_TLBIE: begin
            lk_unit = ilst_pkg::UNIT_LSU;
            lk_ser  = ilst_pkg::SER_EXECUTE;
         end
         ilst_pkg::OP_SYNC: begin
            lk_unit = ilst_pkg::UNIT_LSU;
         end
         ilst_pkg::OP_DIV_WORD: begin
            lk_unit  = ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT;
            lk_lat   = ilst_pkg::LAT_DIV;
            lk_fixed = 1'b1;
            lk_div   = 1'b1;
         end
         default: begin
            lk_unit = ilst_pkg::UNIT_NONE;
         end
      endcase
   end

   // the issue strobe refers to the instruction now on the outputs
   assign iss          = issue & out_valid & ~out_hold;
   assign iss_fp       = iss & (out_unit == ilst_pkg::UNIT_FPU);
   assign iss_fp_empty = iss & (out_ser == ilst_pkg::SER_FP_EMPTY);

   ilst_multi_cycle_int_unit_track u_multi_cycle_int_unit (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .iss_mul_stall (iss & held_mul_stall),
      .iss_div       (iss & held_div),
      .next_busy     (multi_cycle_int_unit_next_busy)
   );

   ilst_fp_track u_fp (
      .clk                  (clk),
      .sys_rst              (sys_rst),
      .iss_fp               (iss_fp),
      .iss_fp_empty         (iss_fp_empty),
      .fp_complete          (fp_complete),
      .next_fp_idle         (fp_next_idle),
      .next_fp_empty_active (fp_next_empty_active)
   );

   // hold is judged against next-cycle state so it stays a flop output
   always_comb begin
      next_out_valid      = dec_valid;
      next_held_mul_stall = dec_valid & lk_mul_stall;
      next_held_div       = dec_valid & lk_div;
      next_out_hold       = 1'b0;
      if (dec_valid) begin
         if ((lk_mul_stall || lk_div || dec_op == ilst_pkg::OP_MUL_WORD ||
              dec_op == ilst_pkg::OP_MULLI) && multi_cycle_int_unit_next_busy) begin
            next_out_hold = 1'b1;
         end
         if (lk_ser == ilst_pkg::SER_FP_EMPTY) begin
            if (!fp_next_idle || fp_next_empty_active) begin
               next_out_hold = 1'b1;
            end
         end else if (lk_unit == ilst_pkg::UNIT_FPU && fp_next_empty_active) begin
            next_out_hold = 1'b1;
         end
      end
      // one-cycle execution, so the flush follows issue by one clock
      next_flush_req = iss & out_flush_on_exec;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_valid         <= 1'b0;
         out_unit          <= ilst_pkg::UNIT_NONE;
         out_latency       <= ilst_pkg::LAT_NONE;
         out_lat_fixed     <= 1'b0;
         out_ser           <= ilst_pkg::SER_NONE;
         out_hold          <= 1'b0;
         out_flush_on_exec <= 1'b0;
         flush_req         <= 1'b0;
         held_mul_stall    <= 1'b0;
         held_div          <= 1'b0;
      end else begin
         out_valid         <= next_out_valid;
         out_unit          <= lk_unit;
         out_latency       <= lk_lat;
         out_lat_fixed     <= lk_fixed;
         out_ser           <= lk_ser;
         out_hold          <= next_out_hold;
         out_flush_on_exec <= lk_flush;
         flush_req         <= next_flush_req;
         held_mul_stall    <= next_held_mul_stall;
         held_div          <= next_held_div;
      end
   end

endmodule // ilst_table

`default_nettype wire

// *** hw/ilst_pkg.sv ***
// Purpose: constants and types for the instruction latency and serialization table
// Assumes: core clock, decoded instruction groups supplied by the decoder
// Notes:   every latency figure is in processor cycles
//
// Contract
// - word multiplies: multi-cycle unit, 4 or 3 cycles
// - multiply-low immediate: multi-cycle unit, 3 cycles
// - cr move: one field simple, else serialized
// - slow moves-from: multi-cycle, 3 cycles, execute
// - link/count moves dispatch-serialized, others execute
// - fixed-point exception move: complete, then flush
// - single stores: load/store unit, 3, execute
// - multiple/string stores: regs plus two cycles
// - simple integer ops: single-cycle unit, unserialized
// - extended subtract-from forms are execute serialized
// - system call, interrupt return: completion, postdispatch
// - fp status register ops: fp unit, 3
// - fp-empty waits for fp unit to drain
// - tlb invalidate execute; barriers unserialized, unfixed
// - stalling multiplies hold stage one; divides iterate
// - everything else issues back to back; fp unit ops wait behind an fp-empty op

package ilst_pkg;

   localparam int LAT_W     = 7;
   localparam int NREG_W    = 6;
   localparam int FP_CNT_W  = 3;
   localparam int DIV_CNT_W = 5;

   localparam logic [LAT_W-1:0] LAT_NONE       = 7'h00;
   localparam logic [LAT_W-1:0] LAT_ONE        = 7'h01;
   localparam logic [LAT_W-1:0] LAT_THREE      = 7'h03;
   localparam logic [LAT_W-1:0] LAT_MUL        = 7'h04;
   localparam logic [LAT_W-1:0] LAT_MUL_EARLY  = 7'h03;
   localparam logic [LAT_W-1:0] LAT_STR_EXTRA  = 7'h02;
   localparam logic [LAT_W-1:0] LAT_FDIV       = 7'h20;
   localparam logic [LAT_W-1:0] LAT_FDIVS      = 7'h12;
   localparam logic [LAT_W-1:0] LAT_DIV        = 7'h14;

   // divide spends all but its first and last stage iterating
   localparam logic [DIV_CNT_W-1:0] DIV_ITER   = 5'h12;

   localparam logic [3:0] CR_ONE_FIELD = 4'h1;

   typedef enum logic [4:0] {
      OP_NONE       = 5'b00000,
      OP_MUL_WORD   = 5'b00001,
      OP_MULLI      = 5'b00010,
      OP_MTCRF      = 5'b00011,
      OP_MF_SLOW    = 5'b00100,
      OP_MT_LRCTR   = 5'b00101,
      OP_MT_MSR_SPR = 5'b00110,
      OP_MT_XER     = 5'b00111,
      OP_STORE      = 5'b01000,
      OP_STORE_MULT = 5'b01001,
      OP_SINGLE_CYCLE_INT_UNIT_SIMPLE= 5'b01010,
      OP_SUBF_EXT   = 5'b01011,
      OP_SC_RFI     = 5'b01100,
      OP_FPSCR      = 5'b01101,
      OP_FP_ARITH   = 5'b01110,
      OP_FDIV       = 5'b01111,
      OP_FDIVS_FRES = 5'b10000,
      OP_TLBIE      = 5'b10001,
      OP_SYNC       = 5'b10010,
      OP_DIV_WORD   = 5'b10011
   } ilst_op_e;

   typedef enum logic [2:0] {
      UNIT_NONE   = 3'b000,
      UNIT_SINGLE_CYCLE_INT_UNIT   = 3'b001,
      UNIT_MULTI_CYCLE_INT_UNIT   = 3'b010,
      UNIT_LSU    = 3'b011,
      UNIT_FPU    = 3'b100,
      UNIT_COMPL  = 3'b101
   } ilst_unit_e;

   typedef enum logic [2:0] {
      SER_NONE      = 3'b000,
      SER_DISPATCH  = 3'b001,
      SER_EXECUTE   = 3'b010,
      SER_DISP_EXEC = 3'b011,
      SER_COMPLETE  = 3'b100,
      SER_POSTDISP  = 3'b101,
      SER_STR_MULT  = 3'b110,
      SER_FP_EMPTY  = 3'b111
   } ilst_ser_e;

   function automatic logic [3:0] ilst_popcount8(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

endpackage

// *** hw/ilst_multi_cycle_int_unit_track.sv ***
// Purpose: occupancy of the three-stage integer multiplier
// Assumes: issue strobes come from logic on the same clock
// Notes:   spr moves share the unit but bypass this tracking
`timescale 1ns/1ns
`default_nettype none

module ilst_multi_cycle_int_unit_track (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic iss_mul_stall,
   input  wire logic iss_div,
   output logic      next_busy
);

   logic                          next_stage1_hold;
   logic [ilst_pkg::DIV_CNT_W-1:0] div_cnt;
   logic [ilst_pkg::DIV_CNT_W-1:0] next_div_cnt;

   always_comb begin
      next_stage1_hold = iss_mul_stall;
      if (iss_div) begin
         next_div_cnt = ilst_pkg::DIV_ITER;
      end else if (div_cnt != '0) begin
         next_div_cnt = div_cnt - 1'b1;
      end else begin
         next_div_cnt = div_cnt;
      end
      // only these two cases block the next multiply or divide
      next_busy = next_stage1_hold | (next_div_cnt != '0);
   end

   always_ff @(posedge clk) begin
      // the one-cycle stage-one stall needs no state of its own
      if (sys_rst) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

endmodule // ilst_multi_cycle_int_unit_track

`default_nettype wire

// *** hw/ilst_fp_track.sv ***
// Purpose: floating-point in-flight count and fp-empty occupancy
// Assumes: one completion pulse per fp unit instruction
// Notes:   counter stops at zero going down but wraps going up; dispatch keeps it sane
`timescale 1ns/1ns
`default_nettype none

module ilst_fp_track (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic iss_fp,
   input  wire logic iss_fp_empty,
   input  wire logic fp_complete,
   output logic      next_fp_idle,
   output logic      next_fp_empty_active
);

   logic [ilst_pkg::FP_CNT_W-1:0] fp_cnt;
   logic [ilst_pkg::FP_CNT_W-1:0] next_fp_cnt;
   logic                          fp_empty_active;

   always_comb begin
      next_fp_cnt = fp_cnt;
      if (iss_fp && !fp_complete) begin
         next_fp_cnt = fp_cnt + 1'b1;
      end else if (!iss_fp && fp_complete && fp_cnt != '0) begin
         next_fp_cnt = fp_cnt - 1'b1;
      end
      // set wins over the clear of the same cycle
      if (iss_fp_empty) begin
         next_fp_empty_active = 1'b1;
      end else if (fp_complete) begin
         next_fp_empty_active = 1'b0;
      end else begin
         next_fp_empty_active = fp_empty_active;
      end
      next_fp_idle = (next_fp_cnt == '0);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fp_cnt          <= '0;
         fp_empty_active <= 1'b0;
      end else begin
         fp_cnt          <= next_fp_cnt;
         fp_empty_active <= next_fp_empty_active;
      end
   end

endmodule // ilst_fp_track

`default_nettype wire

// *** verif/ilst_dispatch_model.sv ***
// Purpose: dispatch and completion side facing the latency table
// Assumes: fp unit finishes each instruction DLY cycles after issue
// Notes:   issue is combinational from the shown outputs
`timescale 1ns/1ns
`default_nettype none
module ilst_dispatch_model #(
   parameter int DLY = 3
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 want,
   input  wire logic                 out_valid,
   input  wire logic                 out_hold,
   input  wire ilst_pkg::ilst_unit_e out_unit,
   output logic                      issue,
   output logic                      fp_complete
);
   logic [7:0] inflt;
   // never issues a held or empty slot
   assign issue = want && out_valid && !out_hold;
   assign fp_complete = inflt[DLY-1];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inflt <= 8'h00;
      end else begin
         inflt <= {inflt[6:0], issue && out_unit == ilst_pkg::UNIT_FPU};
      end
   end
endmodule // ilst_dispatch_model
`default_nettype wire

// *** verif/ilst_table_asserts.sv ***
// Purpose: port checks of the latency and serialization table
// Assumes: single clock, sync reset
// Notes:   divide window tracked by a small counter
`timescale 1ns/1ns
`default_nettype none
module ilst_table_asserts (
   input wire logic                        clk,
   input wire logic                        sys_rst,
   input wire logic                        dec_valid,
   input wire ilst_pkg::ilst_op_e          dec_op,
   input wire logic [7:0]                  dec_crm,
   input wire logic [ilst_pkg::NREG_W-1:0] dec_nregs,
   input wire logic                        dec_early_exit,
   input wire logic                        issue,
   input wire logic                        fp_complete,
   input wire ilst_pkg::ilst_unit_e        out_unit,
   input wire logic [ilst_pkg::LAT_W-1:0]  out_latency,
   input wire logic                        out_lat_fixed,
   input wire ilst_pkg::ilst_ser_e         out_ser,
   input wire logic                        out_valid,
   input wire logic                        out_hold,
   input wire logic                        out_flush_on_exec,
   input wire logic                        flush_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic       acc;
   logic       mul_cls;
   logic [4:0] div_cnt;
   logic [4:0] next_div_cnt;
   assign acc = issue && out_valid && !out_hold;
   assign mul_cls = out_valid && out_unit == ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT && out_ser == ilst_pkg::SER_NONE;
   always_comb begin
      next_div_cnt = div_cnt;
      if (div_cnt != 5'h00) begin
         next_div_cnt = div_cnt - 5'h01;
      end
      if (acc && out_unit == ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT && out_latency == ilst_pkg::LAT_DIV) begin
         next_div_cnt = ilst_pkg::DIV_ITER;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end
   a_store_lookup: assert property (
      dec_valid && dec_op == ilst_pkg::OP_STORE |=> out_unit == ilst_pkg::UNIT_LSU
      && out_latency == 7'h03 && out_ser == ilst_pkg::SER_EXECUTE) else $error("store lookup wrong");
   a_mul_latency: assert property (
      dec_valid && dec_op == ilst_pkg::OP_MUL_WORD |=> out_unit == ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT
      && out_latency == ($past(dec_early_exit) ? 7'h03 : 7'h04)) else $error("multiply latency wrong");
   a_cr_move: assert property (
      dec_valid && dec_op == ilst_pkg::OP_MTCRF |=> out_latency == 7'h01 && (($countones($past(dec_crm)) == 1)
      ? (out_unit == ilst_pkg::UNIT_SINGLE_CYCLE_INT_UNIT && out_ser == ilst_pkg::SER_NONE)
      : (out_unit == ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT && out_ser == ilst_pkg::SER_DISP_EXEC))) else $error("cr move wrong");
   a_multi_store: assert property (
      dec_valid && dec_op == ilst_pkg::OP_STORE_MULT |=> out_latency == {1'b0, $past(dec_nregs)} + 7'h02
      && out_ser == ilst_pkg::SER_STR_MULT) else $error("multiple store wrong");
   a_sys_call: assert property (
      dec_valid && dec_op == ilst_pkg::OP_SC_RFI |=> out_unit == ilst_pkg::UNIT_COMPL
      && !out_lat_fixed && out_ser == ilst_pkg::SER_POSTDISP) else $error("system call wrong");
   a_xer_flush: assert property (
      acc && out_flush_on_exec |=> flush_req) else $error("flush missing");
   a_mul_stall: assert property (
      acc && out_unit == ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT && out_latency == 7'h04 |=> mul_cls |-> out_hold)
      else $error("multiply stall missing");
   a_div_iterate: assert property (
      div_cnt != 5'h00 && mul_cls |-> out_hold) else $error("divide window not held");
endmodule // ilst_table_asserts
bind ilst_table ilst_table_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .dec_valid(dec_valid),
   .dec_op(dec_op), .dec_crm(dec_crm), .dec_nregs(dec_nregs), .dec_early_exit(dec_early_exit),
   .issue(issue), .fp_complete(fp_complete), .out_unit(out_unit), .out_latency(out_latency),
   .out_lat_fixed(out_lat_fixed), .out_ser(out_ser), .out_valid(out_valid), .out_hold(out_hold),
   .out_flush_on_exec(out_flush_on_exec), .flush_req(flush_req));
`default_nettype wire

// *** verif/ilst_table_tb.sv ***
// Purpose: self-checking bench for the latency table
// Assumes: dispatch model issues on request
// Notes:   no random stimulus
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module ilst_table_tb;
   logic                        clk;
   logic                        sys_rst;
   logic                        dec_valid;
   ilst_pkg::ilst_op_e          dec_op;
   logic [7:0]                  dec_crm;
   logic [ilst_pkg::NREG_W-1:0] dec_nregs;
   logic                        dec_early_exit;
   logic                        want;
   wire logic                   issue;
   wire logic                   fp_complete;
   ilst_pkg::ilst_unit_e        out_unit;
   logic [ilst_pkg::LAT_W-1:0]  out_latency;
   logic                        out_lat_fixed;
   ilst_pkg::ilst_ser_e         out_ser;
   logic                        out_valid;
   logic                        out_hold;
   logic                        out_flush_on_exec;
   logic                        flush_req;
   logic [7:0]                  crm_v;
   logic [5:0]                  nr_v;
   logic                        ee_v;
   int                          err_count;
   int                          comparisons;
   int                          n;
   ilst_table uut (.clk(clk), .sys_rst(sys_rst), .dec_valid(dec_valid), .dec_op(dec_op),
      .dec_crm(dec_crm), .dec_nregs(dec_nregs), .dec_early_exit(dec_early_exit), .issue(issue),
      .fp_complete(fp_complete), .out_unit(out_unit), .out_latency(out_latency),
      .out_lat_fixed(out_lat_fixed), .out_ser(out_ser), .out_valid(out_valid), .out_hold(out_hold),
      .out_flush_on_exec(out_flush_on_exec), .flush_req(flush_req));
   ilst_dispatch_model #(.DLY(3)) u_disp (.clk(clk), .sys_rst(sys_rst), .want(want),
      .out_valid(out_valid), .out_hold(out_hold), .out_unit(out_unit), .issue(issue),
      .fp_complete(fp_complete));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic results;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic look(input ilst_pkg::ilst_op_e op, input ilst_pkg::ilst_unit_e u,
                       input logic [6:0] l, input ilst_pkg::ilst_ser_e s);
      @(posedge clk);
      dec_valid <= 1'b1;
      dec_op <= op;
      dec_crm <= crm_v;
      dec_nregs <= nr_v;
      dec_early_exit <= ee_v;
      @(posedge clk);
      #1 `CHK(out_unit, u)
      `CHK(out_latency, l)
      `CHK(out_ser, s)
      `CHK(out_lat_fixed, l != 7'h00)
      `CHK(out_valid, 1'b1)
   endtask
   task automatic t_lookup;
      look(ilst_pkg::OP_MUL_WORD, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h04, ilst_pkg::SER_NONE);
      ee_v = 1'b1;
      look(ilst_pkg::OP_MUL_WORD, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h03, ilst_pkg::SER_NONE);
      look(ilst_pkg::OP_MULLI, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h03, ilst_pkg::SER_NONE);
      look(ilst_pkg::OP_MTCRF, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_DISP_EXEC);
      crm_v = 8'h10;
      look(ilst_pkg::OP_MTCRF, ilst_pkg::UNIT_SINGLE_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_NONE);
      crm_v = 8'h81;
      look(ilst_pkg::OP_MTCRF, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_DISP_EXEC);
      look(ilst_pkg::OP_MF_SLOW, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h03, ilst_pkg::SER_EXECUTE);
      look(ilst_pkg::OP_MT_LRCTR, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_DISPATCH);
      look(ilst_pkg::OP_MT_MSR_SPR, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_EXECUTE);
      look(ilst_pkg::OP_MT_XER, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_COMPLETE);
      look(ilst_pkg::OP_STORE, ilst_pkg::UNIT_LSU, 7'h03, ilst_pkg::SER_EXECUTE);
      look(ilst_pkg::OP_STORE_MULT, ilst_pkg::UNIT_LSU, 7'h02, ilst_pkg::SER_STR_MULT);
      nr_v = 6'h20;
      look(ilst_pkg::OP_STORE_MULT, ilst_pkg::UNIT_LSU, 7'h22, ilst_pkg::SER_STR_MULT);
      look(ilst_pkg::OP_SINGLE_CYCLE_INT_UNIT_SIMPLE, ilst_pkg::UNIT_SINGLE_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_NONE);
      look(ilst_pkg::OP_SUBF_EXT, ilst_pkg::UNIT_SINGLE_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_EXECUTE);
      look(ilst_pkg::OP_SC_RFI, ilst_pkg::UNIT_COMPL, 7'h00, ilst_pkg::SER_POSTDISP);
      look(ilst_pkg::OP_FPSCR, ilst_pkg::UNIT_FPU, 7'h03, ilst_pkg::SER_NONE);
      look(ilst_pkg::OP_TLBIE, ilst_pkg::UNIT_LSU, 7'h00, ilst_pkg::SER_EXECUTE);
      look(ilst_pkg::OP_SYNC, ilst_pkg::UNIT_LSU, 7'h00, ilst_pkg::SER_NONE);
      ee_v = 1'b0;
   endtask
   task automatic t_mul;
      look(ilst_pkg::OP_MUL_WORD, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h04, ilst_pkg::SER_NONE);
      dec_op <= ilst_pkg::OP_MULLI;
      want <= 1'b1;
      @(posedge clk);
      want <= 1'b0;
      #1 `CHK(out_hold, 1'b1)
      @(posedge clk);
      want <= 1'b1;
      #1 `CHK(out_hold, 1'b0)
      @(posedge clk);
      want <= 1'b0;
      #1 `CHK(out_hold, 1'b0)
   endtask
   task automatic t_div;
      look(ilst_pkg::OP_DIV_WORD, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, ilst_pkg::LAT_DIV, ilst_pkg::SER_NONE);
      want <= 1'b1;
      @(posedge clk);
      want <= 1'b0;
      repeat (ilst_pkg::DIV_ITER) begin
         #1 `CHK(out_hold, 1'b1)
         @(posedge clk);
      end
      #1 `CHK(out_hold, 1'b0)
   endtask
   task automatic t_xer;
      look(ilst_pkg::OP_MT_XER, ilst_pkg::UNIT_MULTI_CYCLE_INT_UNIT, 7'h01, ilst_pkg::SER_COMPLETE);
      `CHK(out_flush_on_exec, 1'b1)
      want <= 1'b1;
      dec_op <= ilst_pkg::OP_SINGLE_CYCLE_INT_UNIT_SIMPLE;
      @(posedge clk);
      want <= 1'b0;
      #1 `CHK(flush_req, 1'b1)
      @(posedge clk);
      #1 `CHK(flush_req, 1'b0)
   endtask
   // fdiv must wait out the preceding fp op, then block followers
   task automatic t_fp;
      look(ilst_pkg::OP_FP_ARITH, ilst_pkg::UNIT_FPU, 7'h03, ilst_pkg::SER_NONE);
      want <= 1'b1;
      dec_op <= ilst_pkg::OP_FDIV;
      @(posedge clk);
      #1 `CHK(out_ser, ilst_pkg::SER_FP_EMPTY)
      `CHK(out_hold, 1'b1)
      for (n = 0; n < 10 && out_hold; n++) @(posedge clk) #1;
      `CHK(out_hold, 1'b0)
      @(posedge clk);
      dec_op <= ilst_pkg::OP_FP_ARITH;
      #1 `CHK(out_hold, 1'b1)
      @(posedge clk);
      #1 `CHK(out_hold, 1'b1)
      for (n = 0; n < 10 && out_hold; n++) @(posedge clk) #1;
      `CHK(out_hold, 1'b0)
      @(posedge clk);
      want <= 1'b0;
   endtask
   initial begin
      sys_rst = 1'b1;
      dec_valid = 1'b0;
      dec_op = ilst_pkg::OP_NONE;
      dec_crm = 8'h00;
      dec_nregs = 6'h00;
      dec_early_exit = 1'b0;
      want = 1'b0;
      crm_v = 8'h00;
      nr_v = 6'h00;
      ee_v = 1'b0;
      err_count = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 `CHK(out_valid, 1'b0)
      `CHK(out_unit, ilst_pkg::UNIT_NONE)
      t_lookup();
      t_mul();
      t_div();
      t_xer();
      t_fp();
      results();
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      results();
   end
endmodule // ilst_table_tb
`default_nettype wire
